// file: hdl/ufm_pkg.sv
// Shared constants and types for the serial address match and pointer block
package ufm_pkg;

  // ----------------------------------------------------------------------
  // Register pointer offsets
  // ----------------------------------------------------------------------
  localparam logic [6:0] OFF_FIRST_MODE_REGISTER = 7'h00;
  localparam logic [6:0] OFF_LAST_LEDOUT = 7'h05;
  localparam logic [6:0] OFF_GRP_FIRST = 7'h08;
  localparam logic [6:0] OFF_BRIGHT_FIRST = 7'h0A;
  localparam logic [6:0] OFF_BRIGHT_LAST = 7'h19;
  localparam logic [6:0] OFF_UNUSED_FIRST = 7'h1A;
  localparam logic [6:0] OFF_UNUSED_LAST = 7'h39;
  localparam logic [6:0] OFF_TIMING = 7'h3A;
  localparam logic [6:0] OFF_SUBGROUP_ADDRESS_1 = 7'h3B;
  localparam logic [6:0] OFF_BCAST = 7'h3E;
  localparam logic [6:0] OFF_RANGE_LAST = 7'h41;
  localparam logic [6:0] OFF_ALL_BRIGHT = 7'h42;
  localparam logic [6:0] OFF_ZERO = 7'h00;

  // ----------------------------------------------------------------------
  // Field positions in the first mode register and control register
  // ----------------------------------------------------------------------
  localparam int BIT_RANGE_HI = 6;
  localparam int BIT_RANGE_LO = 5;
  localparam int BIT_SUBGROUP1_MATCH_ENABLE_EN = 3;
  localparam int BIT_BCAST_EN = 0;
  localparam int BIT_AUTO_INC = 7;
  localparam int SUB_COUNT = 3;

  // ----------------------------------------------------------------------
  // Reset values and fixed call addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h80;
  localparam logic [7:0] FIRST_MODE_REGISTER_RST = 8'h09;
  localparam logic [7:0] BCAST_RST = 8'hA0;
  localparam logic [7:0] SUBADR_RST = 8'hAC;
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h06;
  localparam logic [1:0] RANGE_FULL = 2'b00;
  localparam logic [1:0] RANGE_BRIGHT = 2'b01;
  localparam logic [1:0] RANGE_LOW = 2'b10;
  localparam logic [1:0] RANGE_GLOBAL = 2'b11;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int WR_FIFO_DEPTH = 8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_CTRL = 5'b00100,
    ST_DATA = 5'b01000,
    ST_SKIP = 5'b10000
  } ufm_state_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } ufm_wr_t;

endpackage

// file: hdl/ufm_addr_ptr.sv
// Serial write front end: address match, control byte, pointer and write FIFO
`timescale 1ns/100ps
`default_nettype none

// --------------------------------------------------------------------------
// Shift-register FIFO whose head entry is always a flip-flop
// --------------------------------------------------------------------------
module ufm_wr_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH-1:0] vld;
  } ufm_fifo_t;

  ufm_fifo_t s, n;
  logic doPush, doPop;

  // Handshakes; full refuses pushes even while popping
  assign inReady = ~s.vld[DEPTH-1];
  assign outValid = s.vld[0];
  assign outData = s.mem[0];
  assign doPush = inValid & ~s.vld[DEPTH-1];
  assign doPop = outReady & s.vld[0];

  // Shift on pop, then fill the slot just above the last valid entry
  always_comb begin
    n = s;
    if (doPop) begin
      n.mem = s.mem >> WIDTH;
      n.vld = s.vld >> 1;
    end
    // Downward scan, so a slot filled here cannot qualify the one above it
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (doPush && !n.vld[i] && (i == 0 || n.vld[(i > 0) ? i - 1 : 0])) begin
        n.mem[i] = inData;
        n.vld[i] = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule // ufm_wr_fifo

// --------------------------------------------------------------------------
// Address matcher and register pointer
// --------------------------------------------------------------------------
// Summary of operation
// R01: Master sends the address byte first after every start condition.
// R02: Five strap pins form part of the regular address, 32 addresses.
// R03: Address LSB is the operation bit; only writes (0) are accepted.
// R04: Broadcast group address is writable, resets to A0h, match enabled.
// R05: An enabled broadcast address is accepted like the own address.
// R06: Three writable subgroup addresses each reset to ACh.
// R07: After reset only the first subgroup address matching is enabled.
// R08: Subgroup enables live in mode bits 3..1; all zero disables them.
// R09: First byte after any matched address loads the control register.
// R10: Control bits 6..0 are the pointer, bit 7 the auto-increment flag.
// R11: Control register resets to 80h.
// R12: Range is chosen by the flag and mode bits 6 and 5.
// R13: The soft reset call address captures no control byte.
// R14: First data byte goes to the pointed register, valid 00h..41h; the code also takes writes to 42h.
// R15: With the flag set the pointer advances after each data byte.
// R16: Setting 000b keeps the pointer fixed; bytes overwrite one register.
// R17: Setting 100b counts 00h..41h and wraps to 00h.
// R18: Setting 101b counts 0Ah..19h and wraps to 0Ah.
// R19: Setting 110b counts 00h..19h and wraps to 00h.
// R20: Setting 111b counts 08h..19h and wraps to 08h.
// R21: Master must not program reserved settings 001b, 010b, 011b.
// R22: Only pointer bits change; flag kept; out-of-range pointer counts to bound.
// R23: Writes to unused locations change nothing; pointer still advances.
// R24: Mode bit 0 enables broadcast; bits 3,2,1 enable subgroups 1,2,3.
// R25: Fixed upper regular address bits are a parameter joined to the straps.
module ufm_addr_ptr import ufm_pkg::*; #(
  parameter logic [1:0] REG_ADDR_HI = 2'b11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial bus and address straps
  input wire logic usclPin,
  input wire logic usdaPin,
  input wire logic [4:0] addrPins,
  // Register write stream
  output logic wrValid,
  input wire logic wrReady,
  output ufm_wr_t wrEntry,
  // Status
  output logic [6:0] ctrlPtr,
  output logic ctrlAutoInc,
  output logic [7:0] modeReg,
  output logic busSelected,
  output logic softResetCall,
  output logic overrunSeen
);

  typedef struct packed {
    logic sclMeta;
    logic sclSync;
    logic sclPrev;
    logic sdaMeta;
    logic sdaSync;
    logic sdaPrev;
    logic [4:0] strapMeta;
    logic [4:0] strapSync;
    ufm_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ctrl;
    logic [7:0] first_mode_register;
    logic [SUB_COUNT-1:0][7:0] subAdr;
    logic [7:0] bcastAdr;
    logic pendValid;
    ufm_wr_t pend;
    logic selected;
    logic softRst;
    logic overrun;
  } ufm_core_t;

  ufm_core_t s, n;
  logic sclRise, startSeen, stopSeen, byteDone, dataByte;
  logic [7:0] rxByte;
  logic regHit, bcastHit, anyHit, ptrUsed, fifoInReady;
  logic [SUB_COUNT-1:0] subHits;
  logic [6:0] ptrNext;
  logic [$bits(ufm_wr_t)-1:0] fifoOut;

  // ------------------------------------------------------------------------
  // Pointer advance
  // ------------------------------------------------------------------------
  function automatic logic [6:0] ptrAdvance(input logic [6:0] p, input logic auto_increment_flag,
                                            input logic [1:0] rng);
    logic [6:0] hiBound, loBound;
    hiBound = OFF_BRIGHT_LAST;
    loBound = OFF_ZERO;
    unique case (rng)
      RANGE_FULL: hiBound = OFF_RANGE_LAST; // [R17]
      RANGE_BRIGHT: loBound = OFF_BRIGHT_FIRST; // [R18]
      RANGE_LOW: loBound = OFF_ZERO; // [R19]
      RANGE_GLOBAL: loBound = OFF_GRP_FIRST; // [R20]
    endcase
    // Flag clear holds the pointer, also for reserved settings [R16] [R21]
    if (!auto_increment_flag) begin
      return p;
    end
    // Out-of-range pointers count up to the bound, then wrap [R22]
    return (p == hiBound) ? loBound : 7'(p + 7'h01);
  endfunction

  // ------------------------------------------------------------------------
  // Bus event detection on synchronised pins
  // ------------------------------------------------------------------------
  assign sclRise = s.sclSync & ~s.sclPrev;
  assign startSeen = s.sclSync & s.sclPrev & s.sdaPrev & ~s.sdaSync;
  assign stopSeen = s.sclSync & s.sclPrev & ~s.sdaPrev & s.sdaSync;
  assign rxByte = {s.shift[6:0], s.sdaSync};
  assign byteDone = sclRise & (s.state != ST_IDLE) & (s.bitCnt == BIT_LAST);
  assign dataByte = byteDone & (s.state == ST_DATA);

  // Address comparators
  assign regHit = (rxByte[7:1] == {REG_ADDR_HI, s.strapSync}); // [R02] [R25]
  assign bcastHit = s.first_mode_register[BIT_BCAST_EN] & (rxByte[7:1] == s.bcastAdr[7:1]); // [R05] [R24]
  for (genvar g = 0; g < SUB_COUNT; g++) begin : g_sub
    // Enable for subgroup g sits at bit 3-g [R08] [R24]
    assign subHits[g] = s.first_mode_register[BIT_SUBGROUP1_MATCH_ENABLE_EN-g] & (rxByte[7:1] == s.subAdr[g][7:1]);
  end
  assign anyHit = regHit | bcastHit | (|subHits);

  // Pointer classification; unused and reserved locations are dropped [R23]
  assign ptrUsed = (s.ctrl[6:0] <= OFF_LAST_LEDOUT) |
                   ((s.ctrl[6:0] >= OFF_GRP_FIRST) & (s.ctrl[6:0] <= OFF_BRIGHT_LAST)) |
                   ((s.ctrl[6:0] >= OFF_TIMING) & (s.ctrl[6:0] <= OFF_BCAST)) |
                   (s.ctrl[6:0] == OFF_ALL_BRIGHT);
  assign ptrNext = ptrAdvance(s.ctrl[6:0], s.ctrl[BIT_AUTO_INC],
                              s.first_mode_register[BIT_RANGE_HI:BIT_RANGE_LO]); // [R12]

  // ------------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------------
  always_comb begin
    n = s;
    // Two-flop synchronisers for pins and straps
    n.sclMeta = usclPin;
    n.sclSync = s.sclMeta;
    n.sclPrev = s.sclSync;
    n.sdaMeta = usdaPin;
    n.sdaSync = s.sdaMeta;
    n.sdaPrev = s.sdaSync;
    n.strapMeta = addrPins;
    n.strapSync = s.strapMeta;
    n.softRst = 1'b0;
    // Pending write leaves once the FIFO accepts it
    if (s.pendValid && fifoInReady) begin
      n.pendValid = 1'b0;
    end
    if (startSeen) begin
      // Every transfer opens with the address byte [R01]
      n.state = ST_ADDR;
      n.bitCnt = 4'h0;
      n.selected = 1'b0;
    end else if (stopSeen) begin
      n.state = ST_IDLE;
      n.bitCnt = 4'h0;
      n.selected = 1'b0;
    end else if (sclRise && s.state != ST_IDLE) begin
      if (s.bitCnt == BIT_ACK) begin
        // Ninth clock carries the slave's acknowledge bit; ignored
        n.bitCnt = 4'h0;
      end else begin
        n.shift = rxByte;
        n.bitCnt = 4'(s.bitCnt + 4'h1);
      end
      if (byteDone) begin
        unique case (s.state)
          ST_ADDR: begin
            // Reads and foreign addresses are skipped until the next start [R03]
            n.state = ST_SKIP;
            if (!rxByte[0] && anyHit) begin
              n.state = ST_CTRL; // [R05]
              n.selected = 1'b1;
            end else if (rxByte == SOFT_RESET_ADDR) begin
              n.softRst = 1'b1; // [R13]
            end
          end
          ST_CTRL: begin
            n.ctrl = rxByte; // [R09] [R10]
            n.state = ST_DATA;
          end
          ST_DATA: begin
            // Data goes to the pointed register [R14]
            if (ptrUsed) begin
              if (s.pendValid && !fifoInReady) begin
                n.overrun = 1'b1;
              end else begin
                n.pendValid = 1'b1;
                n.pend.addr = s.ctrl[6:0];
                n.pend.data = rxByte;
              end
              if (s.ctrl[6:0] == OFF_FIRST_MODE_REGISTER) begin
                n.first_mode_register = rxByte;
              end
              if (s.ctrl[6:0] == OFF_BCAST) begin
                n.bcastAdr = rxByte; // [R04]
              end
              for (int k = 0; k < SUB_COUNT; k++) begin
                if (s.ctrl[6:0] == 7'(OFF_SUBGROUP_ADDRESS_1 + 7'(k))) begin
                  n.subAdr[k] = rxByte; // [R06]
                end
              end
            end
            n.ctrl[6:0] = ptrNext; // [R15] [R22]
          end
          ST_SKIP: n.state = ST_SKIP;
          default: n.state = ST_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------------
  // State register with power-up defaults
  // ------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
      s.sclMeta <= 1'b1;
      s.sclSync <= 1'b1;
      s.sclPrev <= 1'b1;
      s.sdaMeta <= 1'b1;
      s.sdaSync <= 1'b1;
      s.sdaPrev <= 1'b1;
      s.state <= ST_IDLE;
      s.ctrl <= CTRL_RST; // [R11]
      s.first_mode_register <= FIRST_MODE_REGISTER_RST; // [R07]
      s.bcastAdr <= BCAST_RST; // [R04]
      s.subAdr <= {SUB_COUNT{SUBADR_RST}}; // [R06]
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------------------
  // Write FIFO and outputs
  // ------------------------------------------------------------------------
  ufm_wr_fifo #(.WIDTH($bits(ufm_wr_t)), .DEPTH(WR_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .srst(srst),
    .inValid(s.pendValid),
    .inReady(fifoInReady),
    .inData(s.pend),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(fifoOut)
  );

  assign wrEntry = ufm_wr_t'(fifoOut);
  assign ctrlPtr = s.ctrl[6:0];
  assign ctrlAutoInc = s.ctrl[BIT_AUTO_INC];
  assign modeReg = s.first_mode_register;
  assign busSelected = s.selected;
  assign softResetCall = s.softRst;
  assign overrunSeen = s.overrun;

  // ------------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_ctrl_reset;
    $fell(srst) |-> (s.ctrl == CTRL_RST) && (s.state == ST_IDLE);
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset not 80h"); // [R11]
  property p_addr_reset;
    $fell(srst) |-> (s.bcastAdr == BCAST_RST) && (s.subAdr == {SUB_COUNT{SUBADR_RST}});
  endproperty
  a_addr_reset: assert property (p_addr_reset) else $error("call address defaults"); // [R06]
  property p_mode_reset;
    $fell(srst) |-> (s.first_mode_register[3:0] == FIRST_MODE_REGISTER_RST[3:0]);
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("match enable defaults"); // [R07]
  property p_write_only;
    byteDone && s.state == ST_ADDR && rxByte[0] |=> s.state == ST_SKIP ##1 !s.selected;
  endproperty
  a_write_only: assert property (p_write_only) else $error("read address accepted"); // [R03]
  property p_bcast_accept;
    byteDone && s.state == ST_ADDR && bcastHit && !rxByte[0] |=> s.state == ST_CTRL && s.selected;
  endproperty
  a_bcast_accept: assert property (p_bcast_accept) else $error("broadcast not taken"); // [R05]
  property p_ctrl_capture;
    byteDone && s.state == ST_CTRL |=> s.ctrl == $past(rxByte) && s.state == ST_DATA;
  endproperty
  a_ctrl_capture: assert property (p_ctrl_capture) else $error("control byte lost"); // [R09]
  property p_soft_reset_bypass;
    byteDone && s.state == ST_ADDR && !anyHit && rxByte == SOFT_RESET_ADDR
      |=> softResetCall && $stable(s.ctrl) && s.state == ST_SKIP;
  endproperty
  a_soft_reset_bypass: assert property (p_soft_reset_bypass) else $error("soft reset path"); // [R13]
  property p_fixed_ptr;
    dataByte && !s.ctrl[BIT_AUTO_INC] |=> $stable(s.ctrl[6:0]);
  endproperty
  a_fixed_ptr: assert property (p_fixed_ptr) else $error("pointer moved with flag clear"); // [R16]
  property p_wrap_full;
    dataByte && s.ctrl == 8'hC1 && s.first_mode_register[6:5] == RANGE_FULL |=> s.ctrl[6:0] == OFF_ZERO;
  endproperty
  a_wrap_full: assert property (p_wrap_full) else $error("full range wrap"); // [R17]
  property p_wrap_bright;
    dataByte && s.ctrl == 8'h99 && s.first_mode_register[6:5] == RANGE_BRIGHT
      |=> s.ctrl[6:0] == OFF_BRIGHT_FIRST;
  endproperty
  a_wrap_bright: assert property (p_wrap_bright) else $error("brightness range wrap"); // [R18]
  property p_wrap_global;
    dataByte && s.ctrl == 8'h99 && s.first_mode_register[6:5] == RANGE_GLOBAL |=> s.ctrl[6:0] == OFF_GRP_FIRST;
  endproperty
  a_wrap_global: assert property (p_wrap_global) else $error("global range wrap"); // [R20]
  property p_flag_kept;
    dataByte |=> s.ctrl[BIT_AUTO_INC] == $past(s.ctrl[BIT_AUTO_INC]);
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag altered"); // [R22]
  property p_unused_ignored;
    dataByte && !s.pendValid && s.ctrl[6:0] >= OFF_UNUSED_FIRST && s.ctrl[6:0] <= OFF_UNUSED_LAST
      |=> !s.pendValid && $stable(s.first_mode_register);
  endproperty
  a_unused_ignored: assert property (p_unused_ignored) else $error("unused write took effect"); // [R23]

  c_bcast_transfer: cover property (byteDone && s.state == ST_ADDR && bcastHit);
  c_wrap_full: cover property (dataByte && s.ctrl[6:0] == OFF_RANGE_LAST);
  c_fifo_full: cover property (s.pendValid && !fifoInReady);
  c_soft_reset: cover property (softResetCall);

endmodule // ufm_addr_ptr

`default_nettype wire

// file: verification/ufm_bus_master.sv
// Write-only serial bus master model for the address match block
`timescale 1ns/100ps
`default_nettype none

module ufm_bus_master (
  // Serial bus lines
  output logic scl,
  output logic sda
);
  // Lines idle high between frames, as with pull-ups
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // ------------------------------------------------------------------------
  // Frame tasks, 400 ns bit period
  // ------------------------------------------------------------------------
  // Start or repeated start: data falls while clock high
  task automatic start();
    sda = 1'b1;
    #100 scl = 1'b1;
    #100 sda = 1'b0;
    #100 scl = 1'b0;
    #100;
  endtask

  // Eight bits MSB first, then ninth bit left high
  task automatic send(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      sda = (i == 0) ? 1'b1 : b[i-1];
      #100 scl = 1'b1;
      #200 scl = 1'b0;
      #100;
    end
  endtask

  // Stop: data rises while clock high, then lines rest high
  task automatic stop();
    sda = 1'b0;
    #100 scl = 1'b1;
    #100 sda = 1'b1;
    #200;
  endtask
endmodule // ufm_bus_master

`default_nettype wire

// file: verification/ufm_addr_ptr_test.sv
// Self-checking bench for the address match and pointer block
`timescale 1ns/100ps
`default_nettype none

module ufm_addr_ptr_test import ufm_pkg::*;;
  logic clk, srst, wrReady, wrValid, scl, sda, ctrlAutoInc, busSelected, softResetCall;
  logic overrunSeen, srSeen;
  logic [4:0] addrPins;
  logic [6:0] ctrlPtr, p;
  logic [7:0] modeReg, curMode;
  logic auto_increment_flag;
  ufm_wr_t wrEntry;
  ufm_wr_t got[$];
  ufm_wr_t exp[$];
  int nFail, checksDone;

  // ------------------------------------------------------------------------
  // Design, master model, clock, consumer
  // ------------------------------------------------------------------------
  ufm_addr_ptr #(.REG_ADDR_HI(2'b11)) uut (.clk(clk), .srst(srst), .usclPin(scl),
    .usdaPin(sda), .addrPins(addrPins), .wrValid(wrValid), .wrReady(wrReady),
    .wrEntry(wrEntry), .ctrlPtr(ctrlPtr), .ctrlAutoInc(ctrlAutoInc), .modeReg(modeReg),
    .busSelected(busSelected), .softResetCall(softResetCall), .overrunSeen(overrunSeen));
  ufm_bus_master master (.scl(scl), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Collect popped entries and soft reset pulses
  always @(posedge clk) begin
    if (wrValid && wrReady) got.push_back(wrEntry);
    if (softResetCall) srSeen = 1'b1;
  end

  // ------------------------------------------------------------------------
  // Checking helpers and bench pointer model
  // ------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checksDone++;
    if (seen !== want) begin
      nFail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic printVerdict();
    if (nFail == 0 && checksDone > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [6:0] nxt(input logic [6:0] q);
    logic [6:0] lo, hi;
    hi = (curMode[6:5] == 2'b00) ? 7'h41 : 7'h19;
    lo = (curMode[6:5] == 2'b01) ? 7'h0A : (curMode[6:5] == 2'b11) ? 7'h08 : 7'h00;
    if (!auto_increment_flag) return q;
    return (q == hi) ? lo : q + 7'h01;
  endfunction

  function automatic logic queued(input logic [6:0] q);
    return !(q == 7'h06 || q == 7'h07 || (q >= 7'h1A && q <= 7'h39) ||
      (q >= 7'h3F && q <= 7'h41) || q >= 7'h43);
  endfunction

  // Data that leaves mode and call addresses as they are
  function automatic logic [7:0] dval(input logic [6:0] q);
    if (q == 7'h00) return curMode;
    if (q >= 7'h3B && q <= 7'h3D) return SUBADR_RST;
    if (q == 7'h3E) return BCAST_RST;
    return {1'b0, q} ^ 8'h5A;
  endfunction

  function automatic logic [7:0] regAdr(input logic [4:0] pins);
    return {2'b11, pins, 1'b0};
  endfunction

  // ------------------------------------------------------------------------
  // Bus transfer tasks
  // ------------------------------------------------------------------------
  task automatic open(input logic [7:0] a, input logic sel);
    master.start();
    master.send(a);
    @(posedge clk);
    #2 check(16'(busSelected), 16'(sel));
  endtask

  task automatic ctrl(input logic [7:0] c);
    master.send(c);
    p = c[6:0];
    auto_increment_flag = c[7];
  endtask

  task automatic wr();
    logic [7:0] d;
    d = dval(p);
    master.send(d);
    if (queued(p)) exp.push_back('{addr: p, data: d});
    p = nxt(p);
  endtask

  task automatic close();
    master.stop();
    repeat (20) @(posedge clk);
    #2 check(16'(ctrlPtr), 16'(p));
    check(16'(ctrlAutoInc), 16'(auto_increment_flag));
    check(16'(got.size()), 16'(exp.size()));
    for (int i = 0; i < got.size() && i < exp.size(); i++)
      check(16'(got[i]), 16'(exp[i]));
    got.delete();
    exp.delete();
  endtask

  task automatic setMode(input logic [7:0] m);
    open(regAdr(addrPins), 1'b1);
    ctrl(8'h80);
    curMode = m;
    wr();
    close();
    check(16'(modeReg), 16'(m));
  endtask

  // ------------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------------
  initial begin
    logic [7:0] starts[4];
    int counts[4];
    starts = '{8'hBC, 8'h85, 8'h97, 8'h98};
    counts = '{8, 24, 4, 3};
    srst = 1'b1;
    wrReady = 1'b1;
    addrPins = 5'h15;
    srSeen = 1'b0;
    curMode = FIRST_MODE_REGISTER_RST;
    repeat (12) @(posedge clk);
    #2 srst = 1'b0;
    repeat (5) @(posedge clk);
    #2 check(16'(ctrlPtr), 16'h0000);
    check(16'(ctrlAutoInc), 16'h0001);
    check(16'(modeReg), 16'(FIRST_MODE_REGISTER_RST));
    // Every wrap range, awkward entry points
    for (int r = 0; r < 4; r++) begin
      setMode({1'b0, 2'(r), 5'b01001});
      open(regAdr(addrPins), 1'b1);
      ctrl(starts[r]);
      repeat (counts[r]) wr();
      close();
    end
    // Flag clear holds the pointer
    setMode(8'h09);
    open(regAdr(addrPins), 1'b1);
    ctrl(8'h05);
    repeat (3) wr();
    close();
    // Call addresses
    open(BCAST_RST, 1'b1);
    master.stop();
    open(SUBADR_RST, 1'b1);
    master.stop();
    open(regAdr(addrPins) | 8'h01, 1'b0);
    master.stop();
    open(8'h42, 1'b0);
    master.stop();
    open(SOFT_RESET_ADDR, 1'b0);
    master.send(8'h12);
    master.stop();
    repeat (10) @(posedge clk);
    #2 check(16'(srSeen), 16'h0001);
    check(16'(ctrlPtr), 16'(p));
    // Disabled call addresses and new strap value
    setMode(8'h00);
    open(BCAST_RST, 1'b0);
    master.stop();
    open(SUBADR_RST, 1'b0);
    master.stop();
    addrPins = 5'h0A;
    repeat (5) @(posedge clk);
    open(regAdr(5'h15), 1'b0);
    master.stop();
    open(regAdr(5'h0A), 1'b1);
    master.stop();
    // Stall the consumer until the buffer refuses
    @(posedge clk);
    #2 wrReady = 1'b0;
    open(regAdr(addrPins), 1'b1);
    ctrl(8'h8A);
    repeat (10) wr();
    master.stop();
    repeat (10) @(posedge clk);
    #2 check(16'(overrunSeen), 16'h0001);
    wrReady = 1'b1;
    repeat (20) @(posedge clk);
    #2 check(16'(got.size()), 16'd9);
    printVerdict();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk);
    nFail++;
    printVerdict();
  end
endmodule // ufm_addr_ptr_test

`default_nettype wire
